/* File: verilog/bfxb_exec.sv */
/*
 * Execution stage for field, extend and jump operations.
 * Assumes one request per cycle; condition flags come from the core and are never written here.
 */
// Overview of operation
// (RULE1) Field position 0..31, width 1..32-lsb
// (RULE2) Field clear zeroes width bits
// (RULE3) Field insert copies low source bits
// (RULE4) Signed extract sign extends field
// (RULE5) Unsigned extract zero extends field
// (RULE6) Extend rotates source by bytes first
// (RULE7) Byte extend uses bits 7:0
// (RULE8) Half extend uses bits 15:0
// (RULE9) Field and extend keep flags
// (RULE10) No stack or program counter operands; dst is not checked against BFXB_SP_REG or BFXB_PC_REG
// (RULE11) Linked jumps write next address
// (RULE12) Indirect target clears bit zero
// (RULE13) Indirect with bit zero low traps
// (RULE14) Reach 16 MB, outside-block conditional 1 MB
// (RULE15) Conditions only where block allows; not checked, req_in.cond is honoured on every op outside a block
// (RULE16) Jump in block must be last; not checked, plain and indirect jumps run in any block slot
// (RULE17) No program counter in indirect link
// (RULE18) Jumps keep flags
// (RULE19) Compare jumps test zero, keep flags
// (RULE20) Compare jump register is low
// (RULE21) Compare jump forward 4..130, outside block
// (RULE22) Prefix conditions up to four instructions
// (RULE23) Oversized field result free, flags kept
`timescale 1ns/100ps
`default_nettype none
module bfxb_exec (
  input wire logic clk_in,                 // Core clock, 40 MHz
  input wire logic nrst_in,                // Synchronous reset, active low
  input wire logic valid_in,               // Request valid
  input wire bfxb_pkg::bfxb_req_s req_in,  // Request fields
  input wire logic [3:0] flags_in,         // Core flags N Z C V, read only
  output logic valid_out,                  // Result valid, registered
  output bfxb_pkg::bfxb_rsp_s rsp_out,     // Result, registered
  output logic [3:0] flags_out,            // Flags passed through untouched
  output logic in_block_out                // Conditional block active
);
  import bfxb_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // (RULE23) oversized field results are free
  // Mask of width ones at lsb; oversized fields just truncate
  function automatic logic [31:0] field_mask(input logic [4:0] lsb, input logic [5:0] width);
    logic [63:0] ones;
    ones = (64'h1 << width) - 64'h1;
    field_mask = ones[31:0] << lsb;
  endfunction : field_mask

  // Condition check against flags N Z C V
  function automatic logic cond_pass(input logic [3:0] c, input logic [3:0] f);
    logic base;
    case (c[3:1])
      3'h0: base = f[2];
      3'h1: base = f[1];
      3'h2: base = f[3];
      3'h3: base = f[0];
      3'h4: base = f[1] & ~f[2];
      3'h5: base = (f[3] == f[0]);
      3'h6: base = ~f[2] & (f[3] == f[0]);
      default: base = 1'b1;
    endcase
    cond_pass = (c == BFXB_COND_AL || c == 4'hF) ? 1'b1 : (base ^ c[0]);
  endfunction : cond_pass

  ////////////////////////////////////////////////////////////////////////////
  // Conditional block tracking

  logic [3:0] blk_cond_r;   // Current block condition
  logic [3:0] blk_mask_r;   // Remaining then/else pattern
  logic [2:0] blk_left_r;   // Instructions still in block
  logic [2:0] blk_len;      // Length from mask trailing one
  wire logic in_block = (blk_left_r != 3'h0);
  wire logic is_prefix = valid_in && (req_in.op == BFXB_OP_IF_THEN_PREFIX) && !in_block;
  // Effective condition: block condition, inverted on an else slot
  wire logic [3:0] eff_cond = in_block ?
    {blk_cond_r[3:1], blk_cond_r[0] ^ (blk_mask_r[3] ^ blk_cond_r[0])} : req_in.cond;
  wire logic pass = cond_pass(eff_cond, flags_in);
  assign in_block_out = in_block;

  always_comb begin
    // Position of lowest set mask bit gives block length
    if (req_in.mask[0]) begin
      blk_len = 3'h4;
    end else if (req_in.mask[1]) begin
      blk_len = 3'h3;
    end else if (req_in.mask[2]) begin
      blk_len = 3'h2;
    end else begin
      blk_len = 3'h1;
    end
  end

  // (RULE22) block of up to four
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      blk_left_r <= 3'h0;
      blk_cond_r <= 4'h0;
      blk_mask_r <= 4'h0;
    end else if (is_prefix) begin
      blk_left_r <= (blk_len > BFXB_BLOCK_MAX) ? BFXB_BLOCK_MAX : blk_len;
      blk_cond_r <= req_in.cond;
      blk_mask_r <= {req_in.cond[0], req_in.mask[3:1]};
    end else if (valid_in && in_block) begin
      blk_left_r <= blk_left_r - 3'h1;
      blk_mask_r <= {blk_mask_r[2:0], 1'b0};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Field and extend datapath

  wire logic [31:0] fmask = field_mask(req_in.lsb, req_in.width);
  // (RULE2) clear selected bits only
  wire logic [31:0] clr_val = req_in.dst_val & ~fmask;
  // (RULE3) source bits from bit 0 into field
  wire logic [31:0] ins_val = clr_val | ((req_in.src_val << req_in.lsb) & fmask);
  wire logic [31:0] ext_raw = (req_in.src_val & fmask) >> req_in.lsb;
  wire logic [5:0] top_pos = 6'(req_in.lsb) + req_in.width - 6'h1;
  wire logic ext_sign = req_in.src_val[top_pos[4:0]];
  wire logic [31:0] low_mask = field_mask(5'h0, req_in.width);
  // (RULE4) sign fill above field
  wire logic [31:0] sext_val = ext_raw | ({32{ext_sign}} & ~low_mask);
  // (RULE5) zero fill above field
  wire logic [31:0] uext_val = ext_raw;
  // (RULE6) rotate right by 0, 8, 16 or 24
  wire logic [4:0] rot_amt = {req_in.rot, 3'h0};
  wire logic [63:0] rot_dbl = {req_in.src_val, req_in.src_val} >> rot_amt;
  wire logic [31:0] rot_val = rot_dbl[31:0];
  // (RULE7) byte extend from bits 7:0
  wire logic [31:0] sxb_val = {{24{rot_val[7]}}, rot_val[7:0]};
  wire logic [31:0] zxb_val = {24'h0, rot_val[7:0]};
  // (RULE8) half extend from bits 15:0
  wire logic [31:0] sxh_val = {{16{rot_val[15]}}, rot_val[15:0]};
  wire logic [31:0] zxh_val = {16'h0, rot_val[15:0]};

  ////////////////////////////////////////////////////////////////////////////
  // Jump datapath

  wire logic [31:0] next_pc = req_in.pc + BFXB_INSN_STEP;
  wire logic [31:0] rel_target = next_pc + req_in.offset;
  // (RULE12) bit zero cleared
  wire logic [31:0] ind_target = {req_in.src_val[31:1], 1'b0};
  // (RULE13) bit zero low traps
  wire logic ind_trap = !req_in.src_val[0];
  wire logic [31:0] abs_off = req_in.offset[31] ? (32'h0 - req_in.offset) : req_in.offset;
  wire logic is_cond_jump = (req_in.cond != BFXB_COND_AL) && !in_block;
  // (RULE14) reach depends on block state
  wire logic [31:0] limit = is_cond_jump ? BFXB_NEAR_LIMIT : BFXB_FAR_LIMIT;
  wire logic far_err = req_in.offset[31] ? (abs_off > limit) : (abs_off >= limit);
  wire logic [31:0] cz_dist = rel_target - req_in.pc;
  // (RULE21) forward 4..130 only
  wire logic cz_err = (cz_dist < BFXB_CZ_MIN) || (cz_dist > BFXB_CZ_MAX) || in_block;
  // (RULE19) compare with zero
  wire logic src_zero = (req_in.src_val == 32'h0);

  bfxb_rsp_s rsp_nxt;
  always_comb begin
    rsp_nxt = '0;
    rsp_nxt.wr_reg = req_in.dst;
    if (valid_in && !pass && req_in.op != BFXB_OP_IF_THEN_PREFIX) begin
      rsp_nxt.skipped = 1'b1;
    end else if (valid_in) begin
      case (req_in.op)
        BFXB_OP_FIELD_CLEAR: begin
          rsp_nxt.wr_en = 1'b1;
          rsp_nxt.wr_val = clr_val;
        end
        BFXB_OP_FIELD_INSERT: begin
          rsp_nxt.wr_en = 1'b1;
          rsp_nxt.wr_val = ins_val;
        end
        BFXB_OP_SIGNED_EXTRACT: begin
          rsp_nxt.wr_en = 1'b1;
          rsp_nxt.wr_val = sext_val;
        end
        BFXB_OP_UNSIGNED_EXTRACT: begin
          rsp_nxt.wr_en = 1'b1;
          rsp_nxt.wr_val = uext_val;
        end
        BFXB_OP_SIGN_EXT_BYTE: begin
          rsp_nxt.wr_en = 1'b1;
          rsp_nxt.wr_val = sxb_val;
        end
        BFXB_OP_ZERO_EXT_BYTE: begin
          rsp_nxt.wr_en = 1'b1;
          rsp_nxt.wr_val = zxb_val;
        end
        BFXB_OP_SIGN_EXT_HALF: begin
          rsp_nxt.wr_en = 1'b1;
          rsp_nxt.wr_val = sxh_val;
        end
        BFXB_OP_ZERO_EXT_HALF: begin
          rsp_nxt.wr_en = 1'b1;
          rsp_nxt.wr_val = zxh_val;
        end
        BFXB_OP_JUMP, BFXB_OP_JUMP_LINK: begin
          rsp_nxt.range_err = far_err;
          rsp_nxt.jump = !far_err;
          rsp_nxt.target = rel_target;
          // (RULE11) link to next instruction
          rsp_nxt.wr_en = (req_in.op == BFXB_OP_JUMP_LINK) && !far_err;
          rsp_nxt.wr_reg = BFXB_RET_REG;
          rsp_nxt.wr_val = next_pc;
        end
        BFXB_OP_JUMP_INDIRECT, BFXB_OP_JUMP_INDIRECT_LINK: begin
          // Trap wins: no branch and no link write
          rsp_nxt.trap = ind_trap;
          rsp_nxt.jump = !ind_trap;
          rsp_nxt.target = ind_target;
          // (RULE11) link on taken indirect
          rsp_nxt.wr_en = (req_in.op == BFXB_OP_JUMP_INDIRECT_LINK) && !ind_trap;
          rsp_nxt.wr_reg = BFXB_RET_REG;
          rsp_nxt.wr_val = next_pc;
        end
        BFXB_OP_COMPARE_ZERO_JUMP, BFXB_OP_COMPARE_NONZERO_JUMP: begin
          rsp_nxt.range_err = cz_err;
          rsp_nxt.jump = !cz_err && (src_zero == (req_in.op == BFXB_OP_COMPARE_ZERO_JUMP));
          rsp_nxt.target = rel_target;
        end
        default: begin
          rsp_nxt.wr_en = 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output registers

  // Result stage; flags never rewritten
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      rsp_out <= '0;
      valid_out <= 1'b0;
    end else begin
      rsp_out <= rsp_nxt;
      valid_out <= valid_in;
    end
  end

  // (RULE9) (RULE18) flags pass unchanged
  assign flags_out = flags_in;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  sequence ind_req_s;
    valid_in && pass && !in_block && req_in.op == BFXB_OP_JUMP_INDIRECT_LINK;
  endsequence

  linked_write_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // (RULE11)
    (ind_req_s and req_in.src_val[0]) |=> rsp_out.wr_en && rsp_out.wr_reg == BFXB_RET_REG &&
    rsp_out.wr_val == $past(req_in.pc) + BFXB_INSN_STEP)
    else $error("link write missing");
  trap_raise_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // (RULE13)
    (ind_req_s and !req_in.src_val[0]) |=> rsp_out.trap && !rsp_out.jump && !rsp_out.wr_en)
    else $error("trap not raised");
  target_even_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // (RULE12)
    valid_out && rsp_out.jump |-> !rsp_out.target[0])
    else $error("odd jump target");
  flags_kept_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // (RULE18)
    flags_out == flags_in)
    else $error("flags modified");
  clear_field_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // (RULE2)
    valid_in && pass && !in_block && req_in.op == BFXB_OP_FIELD_CLEAR
    |=> (rsp_out.wr_val & $past(fmask)) == 32'h0 &&
    (rsp_out.wr_val & ~$past(fmask)) == ($past(req_in.dst_val) & ~$past(fmask)))
    else $error("field clear wrong");
  byte_zero_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // (RULE7)
    valid_in && pass && !in_block && req_in.op == BFXB_OP_ZERO_EXT_BYTE
    |=> rsp_out.wr_val[31:8] == 24'h0)
    else $error("byte zero fill wrong");
  half_sign_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // (RULE8)
    valid_in && pass && !in_block && req_in.op == BFXB_OP_SIGN_EXT_HALF
    |=> rsp_out.wr_val[31:16] == {16{rsp_out.wr_val[15]}})
    else $error("half sign fill wrong");
  cz_taken_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // (RULE19)
    valid_in && !in_block && req_in.op == BFXB_OP_COMPARE_ZERO_JUMP && !src_zero
    |=> !rsp_out.jump)
    else $error("compare zero jump taken");
  block_len_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // (RULE22)
    blk_left_r <= BFXB_BLOCK_MAX)
    else $error("block too long");
endmodule : bfxb_exec
`default_nettype wire

/* File: verilog/bfxb_pkg.sv */
/*
 * Package for the bitfield, extend and jump execution block.
 * Holds operation codes, condition codes, operand and result structs and range constants.
 * Assumes a 32-bit core with sixteen registers and a return address register at index 14.
 */
package bfxb_pkg;
  localparam int unsigned BFXB_XLEN = 32;          // Datapath width
  localparam logic [3:0] BFXB_RET_REG = 4'hE;      // Return address register index
  localparam logic [3:0] BFXB_SP_REG = 4'hD;       // Stack pointer register index
  localparam logic [3:0] BFXB_PC_REG = 4'hF;       // Program counter register index
  localparam logic [31:0] BFXB_FAR_LIMIT = 32'h0100_0000;  // 16 MB reach
  localparam logic [31:0] BFXB_NEAR_LIMIT = 32'h0010_0000; // 1 MB reach
  localparam logic [31:0] BFXB_CZ_MIN = 32'h0000_0004;     // Least forward distance
  localparam logic [31:0] BFXB_CZ_MAX = 32'h0000_0082;     // Greatest forward distance
  localparam logic [31:0] BFXB_INSN_STEP = 32'h0000_0004;  // Next instruction distance
  localparam logic [3:0] BFXB_COND_AL = 4'hE;      // Always condition
  localparam logic [2:0] BFXB_BLOCK_MAX = 3'h4;    // Longest conditional block

  // Operations handled here
  typedef enum logic [4:0] {
    BFXB_OP_NONE,
    BFXB_OP_FIELD_CLEAR,
    BFXB_OP_FIELD_INSERT,
    BFXB_OP_SIGNED_EXTRACT,
    BFXB_OP_UNSIGNED_EXTRACT,
    BFXB_OP_SIGN_EXT_BYTE,
    BFXB_OP_ZERO_EXT_BYTE,
    BFXB_OP_SIGN_EXT_HALF,
    BFXB_OP_ZERO_EXT_HALF,
    BFXB_OP_JUMP,
    BFXB_OP_JUMP_LINK,
    BFXB_OP_JUMP_INDIRECT,
    BFXB_OP_JUMP_INDIRECT_LINK,
    BFXB_OP_COMPARE_ZERO_JUMP,
    BFXB_OP_COMPARE_NONZERO_JUMP,
    BFXB_OP_IF_THEN_PREFIX
  } bfxb_op_e;

  // One issued instruction
  typedef struct packed {
    bfxb_op_e op;            // Operation
    logic [3:0] cond;        // Condition code
    logic [3:0] mask;        // Conditional block then/else mask
    logic [3:0] dst;         // Destination register index
    logic [31:0] dst_val;    // Current destination value
    logic [31:0] src_val;    // First or second source value
    logic [4:0] lsb;         // Field low position
    logic [5:0] width;       // Field width
    logic [1:0] rot;         // Rotation in bytes
    logic [31:0] pc;         // Instruction address
    logic [31:0] offset;     // Signed branch offset
  } bfxb_req_s;

  // One result
  typedef struct packed {
    logic wr_en;             // Register write
    logic [3:0] wr_reg;      // Written register
    logic [31:0] wr_val;     // Written value
    logic jump;              // Branch taken
    logic [31:0] target;     // Branch target
    logic trap;              // Misuse trap
    logic range_err;         // Offset out of reach
    logic skipped;           // Condition failed
  } bfxb_rsp_s;
endpackage : bfxb_pkg

/* File: dv/bfxb_stream.sv */
/* Instruction stream model for the field, extend and jump block.
   Assumes the bench loads one request at a time through go_in. */
`timescale 1ns/100ps
`default_nettype none
module bfxb_stream (
  input wire logic clk_in,                 // Core clock
  input wire logic go_in,                  // Present a request
  input wire bfxb_pkg::bfxb_req_s req_in,  // Request to present
  output logic valid_out,                  // Request valid
  output bfxb_pkg::bfxb_req_s req_out      // Request fields
);
  import bfxb_pkg::*;
  initial begin
    valid_out = 1'b0;
    req_out = '0;
  end
  ////////////////////////////////////////
  // Present on the falling edge, settled for the block's rising edge
  // legal operand fields
  always @(negedge clk_in) begin
    valid_out <= go_in;
    // Idle fields flip, so a stale request never looks alive
    req_out <= go_in ? req_in : ~req_out;
  end
endmodule : bfxb_stream
`default_nettype wire

/* File: dv/bfxb_exec_tb.sv */
/* Self-checking bench for the field, extend and jump block.
   Assumes the stream model feeds requests; flags come from the bench. */
`timescale 1ns/100ps
`default_nettype none
module bfxb_exec_tb;
  import bfxb_pkg::*;
  logic clk_in, nrst_in, go, valid, valid_out, in_block_out;
  logic [3:0] flags, flags_out;  // Core flags in and out
  bfxb_req_s r, rq;              // Loaded and presented request
  bfxb_rsp_s rsp;                // Block result
  int fails, total_checks, cyc;
  bfxb_stream src (.clk_in(clk_in), .go_in(go), .req_in(r), .valid_out(valid),
    .req_out(rq));
  bfxb_exec uut (.clk_in(clk_in), .nrst_in(nrst_in), .valid_in(valid), .req_in(rq),
    .flags_in(flags), .valid_out(valid_out), .rsp_out(rsp), .flags_out(flags_out),
    .in_block_out(in_block_out));
  ////////////////////////////////////////
  // Helpers
  function automatic bfxb_req_s fld(bfxb_op_e op, logic [31:0] dv, logic [31:0] sv,
      logic [4:0] lsb, logic [5:0] w);
    return '{op, BFXB_COND_AL, 4'h0, 4'h4, dv, sv, lsb, w, 2'h0, 32'h0, 32'h0};
  endfunction : fld
  function automatic bfxb_req_s jmp(bfxb_op_e op, logic [3:0] c, logic [31:0] sv,
      logic [31:0] pc, logic [31:0] off);
    return '{op, c, 4'h0, 4'h0, 32'h0, sv, 5'h0, 6'h0, 2'h0, pc, off};
  endfunction : jmp
  function automatic bfxb_rsp_s ew(logic [31:0] v);
    return '{1'b1, 4'h4, v, 1'b0, 32'h0, 1'b0, 1'b0, 1'b0};
  endfunction : ew
  function automatic bfxb_rsp_s ej(logic lk, logic [31:0] pc, logic [31:0] t);
    return '{lk, BFXB_RET_REG, pc + BFXB_INSN_STEP, 1'b1, t, 1'b0, 1'b0, 1'b0};
  endfunction : ej
  function automatic bfxb_rsp_s ef(logic tr, logic re, logic sk);
    return '{1'b0, 4'h0, 32'h0, 1'b0, 32'h0, tr, re, sk};
  endfunction : ef
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // One request through the stream, judged on the falling edge after the block takes it
  task automatic run(input bfxb_req_s q, input bfxb_rsp_s e, input logic [3:0] f = 4'hA,
      input logic ib = 1'b0, input logic full = 1'b1);
    @(negedge clk_in);
    go <= 1'b1;
    r <= q;
    @(negedge clk_in);
    go <= 1'b0;
    flags <= f;
    @(negedge clk_in);
    chk("valid_out", 32'h1, {31'h0, valid_out});
    chk("flags_out", {28'h0, f}, {28'h0, flags_out});
    chk("in_block_out", {31'h0, ib}, {31'h0, in_block_out});
    if (full) begin
      chk("wr_en", {31'h0, e.wr_en}, {31'h0, rsp.wr_en});
      if (e.wr_en) begin
        chk("wr_reg", {28'h0, e.wr_reg}, {28'h0, rsp.wr_reg});
        chk("wr_val", e.wr_val, rsp.wr_val);
      end
      chk("jump", {31'h0, e.jump}, {31'h0, rsp.jump});
      if (e.jump) begin
        chk("target", e.target, rsp.target);
      end
      chk("trap", {31'h0, e.trap}, {31'h0, rsp.trap});
      chk("range_err", {31'h0, e.range_err}, {31'h0, rsp.range_err});
      chk("skipped", {31'h0, e.skipped}, {31'h0, rsp.skipped});
    end
  endtask : run
  task automatic pfx(input logic [3:0] c, input logic [3:0] m, input logic [3:0] f);
    run('{BFXB_OP_IF_THEN_PREFIX, c, m, 4'h0, 32'h0, 32'h0, 5'h0, 6'h0, 2'h0, 32'h0,
      32'h0}, ef(1'b0, 1'b0, 1'b0), f, 1'b1, 1'b0);
  endtask : pfx
  ////////////////////////////////////////
  // Scenarios
  task automatic t_field;
    run(fld(BFXB_OP_FIELD_CLEAR, 32'hFFFF_FFFF, 32'h0, 5'h08, 6'h0C), ew(32'hFFF0_00FF));
    run(fld(BFXB_OP_FIELD_CLEAR, 32'hFFFF_FFFF, 32'h0, 5'h1F, 6'h01), ew(32'h7FFF_FFFF));
    run(fld(BFXB_OP_FIELD_INSERT, 32'hFFFF_FFFF, 32'h1234_5ABC, 5'h08, 6'h0C),
      ew(32'hFFFA_BCFF));
    run(fld(BFXB_OP_FIELD_INSERT, 32'h0, 32'h89AB_CDEF, 5'h00, 6'h20), ew(32'h89AB_CDEF));
    run(fld(BFXB_OP_SIGNED_EXTRACT, 32'h0, 32'h0080_0000, 5'h14, 6'h04), ew(32'hFFFF_FFF8));
    run(fld(BFXB_OP_SIGNED_EXTRACT, 32'h0, 32'h8000_0000, 5'h1F, 6'h01), ew(32'hFFFF_FFFF));
    run(fld(BFXB_OP_UNSIGNED_EXTRACT, 32'h0, 32'hFFFF_FFFF, 5'h09, 6'h0A), ew(32'h3FF), 4'h5);
  endtask : t_field
  task automatic t_extend;
    logic [31:0] sv;
    logic [31:0] v;
    sv = 32'h80FF_7F01;
    // Rotations 0 and 1 bring a positive byte to the bottom, rotations 2 and 3 a negative one
    for (int k = 0; k < 4; k++) begin
      v = 32'({sv, sv} >> (8 * k));
      r.rot = 2'(k);
      run('{BFXB_OP_SIGN_EXT_BYTE, BFXB_COND_AL, 4'h0, 4'h4, 32'h0, sv, 5'h0, 6'h0, 2'(k),
        32'h0, 32'h0}, ew({{24{v[7]}}, v[7:0]}));
      run('{BFXB_OP_ZERO_EXT_BYTE, BFXB_COND_AL, 4'h0, 4'h4, 32'h0, sv, 5'h0, 6'h0, 2'(k),
        32'h0, 32'h0}, ew({24'h0, v[7:0]}), 4'hF);
      run('{BFXB_OP_SIGN_EXT_HALF, BFXB_COND_AL, 4'h0, 4'h4, 32'h0, sv, 5'h0, 6'h0, 2'(k),
        32'h0, 32'h0}, ew({{16{v[15]}}, v[15:0]}));
      run('{BFXB_OP_ZERO_EXT_HALF, BFXB_COND_AL, 4'h0, 4'h4, 32'h0, sv, 5'h0, 6'h0, 2'(k),
        32'h0, 32'h0}, ew({16'h0, v[15:0]}));
    end
  endtask : t_extend
  task automatic t_jump;
    run(jmp(BFXB_OP_JUMP_LINK, 4'hE, 32'h0, 32'h100, 32'h20), ej(1'b1, 32'h100, 32'h124));
    run(jmp(BFXB_OP_JUMP, 4'hE, 32'h0, 32'h100, 32'h00FF_FFFE), ej(1'b0, 0, 32'h0100_0102));
    run(jmp(BFXB_OP_JUMP, 4'hE, 32'h0, 32'h100, 32'h0100_0000), ef(1'b0, 1'b1, 1'b0));
    run(jmp(BFXB_OP_JUMP_LINK, 4'hE, 32'h0, 32'h100, 32'hFF00_0000),
      ej(1'b1, 32'h100, 32'hFF00_0104), 4'hF);
    run(jmp(BFXB_OP_JUMP, 4'h0, 32'h0, 32'h100, 32'h0010_0000), ef(1'b0, 1'b1, 1'b0), 4'h4);
    run(jmp(BFXB_OP_JUMP, 4'h0, 32'h0, 32'h100, 32'h000F_FFFE), ej(1'b0, 0, 32'h0010_0102),
      4'h4);
    run(jmp(BFXB_OP_JUMP, 4'h0, 32'h0, 32'h100, 32'h20), ef(1'b0, 1'b0, 1'b1), 4'h0);
    run(jmp(BFXB_OP_JUMP_INDIRECT_LINK, 4'hE, 32'h2001, 32'h100, 32'h0),
      ej(1'b1, 32'h100, 32'h2000));
    run(jmp(BFXB_OP_JUMP_INDIRECT, 4'hE, 32'h3003, 32'h100, 32'h0), ej(1'b0, 0, 32'h3002));
    run(jmp(BFXB_OP_JUMP_INDIRECT, 4'hE, 32'h2000, 32'h100, 32'h0), ef(1'b1, 1'b0, 1'b0));
    run(jmp(BFXB_OP_JUMP_INDIRECT_LINK, 4'hE, 32'h2000, 32'h100, 32'h0),
      ef(1'b1, 1'b0, 1'b0));
  endtask : t_jump
  task automatic t_cmp;
    run(jmp(BFXB_OP_COMPARE_ZERO_JUMP, 4'hE, 32'h0, 32'h200, 32'h7E), ej(1'b0, 0, 32'h282));
    run(jmp(BFXB_OP_COMPARE_ZERO_JUMP, 4'hE, 32'h0, 32'h200, 32'h0), ej(1'b0, 0, 32'h204));
    run(jmp(BFXB_OP_COMPARE_ZERO_JUMP, 4'hE, 32'h0, 32'h200, 32'h80), ef(1'b0, 1'b1, 1'b0));
    run(jmp(BFXB_OP_COMPARE_ZERO_JUMP, 4'hE, 32'h5, 32'h200, 32'h10), ef(1'b0, 1'b0, 1'b0));
    run(jmp(BFXB_OP_COMPARE_NONZERO_JUMP, 4'hE, 32'h0, 32'h200, 32'h10),
      ef(1'b0, 1'b0, 1'b0));
    run(jmp(BFXB_OP_COMPARE_NONZERO_JUMP, 4'hE, 32'h1, 32'h200, 32'h10), ej(1'b0, 0, 32'h214),
      4'hF);
  endtask : t_cmp
  task automatic t_block;
    pfx(4'h0, 4'h8, 4'h0);
    run(fld(BFXB_OP_FIELD_CLEAR, 32'hFF, 32'h0, 5'h0, 6'h4), ef(1'b0, 1'b0, 1'b1), 4'h0);
    pfx(4'h1, 4'hC, 4'h0);
    run(fld(BFXB_OP_FIELD_CLEAR, 32'hFF, 32'h0, 5'h0, 6'h4), ew(32'hF0), 4'h0, 1'b1);
    run(jmp(BFXB_OP_JUMP, 4'h1, 32'h0, 32'h100, 32'h0010_0000), ej(1'b0, 0, 32'h0010_0104),
      4'h0);
    // Second slot is an else slot: inverse condition fails
    pfx(4'h1, 4'h4, 4'h0);
    run(fld(BFXB_OP_FIELD_CLEAR, 32'hFF, 32'h0, 5'h0, 6'h4), ew(32'hF0), 4'h0, 1'b1);
    run(fld(BFXB_OP_FIELD_CLEAR, 32'hFF, 32'h0, 5'h0, 6'h4), ef(1'b0, 1'b0, 1'b1), 4'h0);
    pfx(4'hE, 4'h8, 4'h0);
    run(jmp(BFXB_OP_COMPARE_ZERO_JUMP, 4'hE, 32'h0, 32'h200, 32'h10), ef(1'b0, 1'b1, 1'b0));
  endtask : t_block
  ////////////////////////////////////////
  // Verdict, clock, watchdog and main sequence
  task automatic results;
    if (fails == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : results
  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    // Ceiling well above the some 160 cycles the scenarios need
    if (cyc == 3000) begin
      fails++;
      results();
    end
  end
  initial begin
    cyc = 0;
    fails = 0;
    total_checks = 0;
    nrst_in = 1'b0;
    go = 1'b0;
    r = '0;
    flags = 4'h0;
    repeat (8) @(negedge clk_in);
    chk("reset valid_out", 32'h0, {31'h0, valid_out});
    chk("reset in_block_out", 32'h0, {31'h0, in_block_out});
    nrst_in <= 1'b1;
    t_field();
    t_extend();
    t_jump();
    t_cmp();
    t_block();
    results();
  end
endmodule : bfxb_exec_tb
`default_nettype wire
